// ---- core/flash_host.sv ----
// Host controller that runs flash bus cycles and the toggle-bit status check.
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Status reads may use output enable or chip select as strobe.
// - Host reads status twice in a row and compares toggle flags.
// - Toggling with fail flag high: recheck; still toggling means failure, reset.
// - Host resuming after other work restarts from the first double read.
// - After any fail flag failure the host writes the reset command.
// - Host may skip window checks only if erase commands come under 50 us.
// - Host checks window flag before and after each added sector erase.
// - Host presents a valid address when reading poll or toggle two flags.
module flash_host #(
  parameter logic [7:0] RESET_CMD = 8'hf0,
  parameter int         ADDR_W    = 20
) (
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  output logic [ADDR_W-1:0]      flashAddr,
  input  wire logic [7:0]        dqIn,
  output logic [7:0]             dqOut,
  output logic                   dqOe,
  output logic                   ceN,
  output logic                   oeN,
  output logic                   weN,
  input  wire logic              readyBusyIn
);

  // Synchronisers for the asynchronous flash pins.
  logic [7:0]        dqMeta_q;
  logic [7:0]        dqSync_q;
  logic              rbMeta_q;
  logic              rbSync_q;
  // Register file and command launch.
  logic              wrPend_q;
  logic [7:0]        wrAddr_q;
  logic [ADDR_W-1:0] addrReg_q;
  logic [7:0]        wdataReg_q;
  logic [7:0]        rdataReg_q;
  logic              startCmd_q;
  logic [2:0]        cmd_q;
  // Bus cycle engine.
  flash_host_pkg::cyc_t cyc_q;
  logic [3:0]        cycCnt_q;
  logic              cycReq_q;
  logic              cycWr_q;
  logic [7:0]        cycData_q;
  logic              cycDone_q;
  logic [7:0]        cycRd_q;
  // Sequencer and result flags.
  flash_host_pkg::seq_t seq_q;
  logic [7:0]        first_q;
  logic              ok_q;
  logic              fail_q;
  logic              toggles_q;
  logic              tog2_q;
  logic              winPre_q;
  logic              winPost_q;
  logic              reject_q;
  logic [2:0]        readCount_q;

  wire logic seqIdle = (seq_q == flash_host_pkg::S_IDLE);
  wire logic tog1Diff = first_q[flash_host_pkg::TOGGLE1_BIT]
                        ^ cycRd_q[flash_host_pkg::TOGGLE1_BIT];

  // Word read mux; unmapped offsets read as zero.
  function automatic logic [31:0] regRead(input logic [7:0] ofs);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (ofs)
      flash_host_pkg::CTRL_OFS:   v = {29'h0, cmd_q};
      flash_host_pkg::ADDR_OFS:   v = 32'(addrReg_q);
      flash_host_pkg::WDATA_OFS:  v = {24'h0, wdataReg_q};
      flash_host_pkg::RDATA_OFS:  v = {24'h0, rdataReg_q};
      flash_host_pkg::STATUS_OFS: begin
        v[flash_host_pkg::ST_BUSY]    = !seqIdle;
        v[flash_host_pkg::ST_OK]      = ok_q;
        v[flash_host_pkg::ST_FAIL]    = fail_q;
        v[flash_host_pkg::ST_TOGGLES] = toggles_q;
        v[flash_host_pkg::ST_TOG2]    = tog2_q;
        v[flash_host_pkg::ST_WINPRE]  = winPre_q;
        v[flash_host_pkg::ST_WINPOST] = winPost_q;
        v[flash_host_pkg::ST_REJECT]  = reject_q;
        v[flash_host_pkg::ST_READY]   = rbSync_q;
      end
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Two flops on every pin input; only the second stage is used by logic.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dqMeta_q <= 8'h00;
      dqSync_q <= 8'h00;
      rbMeta_q <= 1'b0;
      rbSync_q <= 1'b0;
    end else begin
      dqMeta_q <= dqIn;
      dqSync_q <= dqMeta_q;
      rbMeta_q <= readyBusyIn;
      rbSync_q <= rbMeta_q;
    end
  end

  // AHB-Lite slave with zero wait states; read data is fetched in the address phase.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h0000_0000;
      wrPend_q   <= 1'b0;
      wrAddr_q   <= 8'h00;
      addrReg_q  <= '0;
      wdataReg_q <= 8'h00;
      cmd_q      <= 3'h0;
      startCmd_q <= 1'b0;
    end else begin
      startCmd_q <= 1'b0;
      wrPend_q   <= hready && hsel && htrans[1] && hwrite;
      wrAddr_q   <= haddr[7:0];
      if (hready && hsel && htrans[1] && !hwrite) begin
        hrdata <= regRead(haddr[7:0]);
      end
      if (wrPend_q) begin
        unique case (wrAddr_q)
          flash_host_pkg::ADDR_OFS:  addrReg_q  <= hwdata[ADDR_W-1:0];
          flash_host_pkg::WDATA_OFS: wdataReg_q <= hwdata[7:0];
          // A command written while one runs is dropped, so software must poll busy first.
          flash_host_pkg::CTRL_OFS: begin
            if (seqIdle) begin
              cmd_q      <= hwdata[2:0];
              startCmd_q <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Bus cycle engine: both strobes low for a read, so either one delimits the cycle.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cyc_q     <= flash_host_pkg::C_IDLE;
      cycCnt_q  <= 4'h0;
      cycDone_q <= 1'b0;
      cycRd_q   <= 8'h00;
      ceN       <= 1'b1;
      oeN       <= 1'b1;
      weN       <= 1'b1;
      dqOe      <= 1'b0;
      dqOut     <= 8'h00;
    end else begin
      cycDone_q <= 1'b0;
      unique case (cyc_q)
        flash_host_pkg::C_IDLE: begin
          if (cycReq_q) begin
            ceN <= 1'b0;
            if (cycWr_q) begin
              weN      <= 1'b0;
              dqOe     <= 1'b1;
              dqOut    <= cycData_q;
              cycCnt_q <= 4'(flash_host_pkg::WP_CYCLES - 1);
              cyc_q    <= flash_host_pkg::C_WRITE;
            end else begin
              oeN      <= 1'b0;
              cycCnt_q <= 4'(flash_host_pkg::READ_CYCLES - 1);
              cyc_q    <= flash_host_pkg::C_READ;
            end
          end
        end
        flash_host_pkg::C_READ: begin
          if (cycCnt_q == 4'h0) begin
            // The synchroniser delay is part of the strobe time, so this is settled data.
            cycRd_q  <= dqSync_q;
            oeN      <= 1'b1;
            ceN      <= 1'b1;
            cycCnt_q <= 4'(flash_host_pkg::GAP_CYCLES - 1);
            cyc_q    <= flash_host_pkg::C_GAP;
          end else begin
            cycCnt_q <= cycCnt_q - 4'h1;
          end
        end
        flash_host_pkg::C_WRITE: begin
          if (cycCnt_q == 4'h0) begin
            weN      <= 1'b1;
            ceN      <= 1'b1;
            cycCnt_q <= 4'(flash_host_pkg::GAP_CYCLES - 1);
            cyc_q    <= flash_host_pkg::C_GAP;
          end else begin
            cycCnt_q <= cycCnt_q - 4'h1;
          end
        end
        flash_host_pkg::C_GAP: begin
          // Data stays driven through the gap to give hold time after the write strobe.
          if (cycCnt_q == 4'h0) begin
            dqOe      <= 1'b0;
            cycDone_q <= 1'b1;
            cyc_q     <= flash_host_pkg::C_IDLE;
          end else begin
            cycCnt_q <= cycCnt_q - 4'h1;
          end
        end
        default: cyc_q <= flash_host_pkg::C_IDLE;
      endcase
    end
  end

  // Command sequencer: toggle check, failure recovery and guarded sector-erase add.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      seq_q      <= flash_host_pkg::S_IDLE;
      cycReq_q   <= 1'b0;
      cycWr_q    <= 1'b0;
      cycData_q  <= 8'h00;
      first_q    <= 8'h00;
      rdataReg_q <= 8'h00;
      flashAddr  <= '0;
      ok_q       <= 1'b0;
      fail_q     <= 1'b0;
      toggles_q  <= 1'b0;
      tog2_q     <= 1'b0;
      winPre_q   <= 1'b0;
      winPost_q  <= 1'b0;
      reject_q   <= 1'b0;
    end else begin
      cycReq_q <= 1'b0;
      unique case (seq_q)
        flash_host_pkg::S_IDLE: begin
          if (startCmd_q) begin
            // Every poll begins again at its first double read, never mid-way.
            flashAddr <= addrReg_q;
            ok_q      <= 1'b0;
            fail_q    <= 1'b0;
            toggles_q <= 1'b0;
            tog2_q    <= 1'b0;
            reject_q  <= 1'b0;
            cycReq_q  <= 1'b1;
            cycWr_q   <= 1'b0;
            unique case (cmd_q)
              flash_host_pkg::CMD_READ:   seq_q <= flash_host_pkg::S_SINGLE;
              flash_host_pkg::CMD_POLL:   seq_q <= flash_host_pkg::S_RD1;
              flash_host_pkg::CMD_SECTOR: seq_q <= flash_host_pkg::S_PRE;
              flash_host_pkg::CMD_WRITE: begin
                cycWr_q   <= 1'b1;
                cycData_q <= wdataReg_q;
                seq_q     <= flash_host_pkg::S_SINGLE;
              end
              flash_host_pkg::CMD_RESET: begin
                cycWr_q   <= 1'b1;
                cycData_q <= RESET_CMD;
                seq_q     <= flash_host_pkg::S_RESET;
              end
              default: begin
                cycReq_q <= 1'b0;
                seq_q    <= flash_host_pkg::S_IDLE;
              end
            endcase
          end
        end
        flash_host_pkg::S_SINGLE: begin
          if (cycDone_q) begin
            if (!cycWr_q) begin
              rdataReg_q <= cycRd_q;
            end
            ok_q  <= 1'b1;
            seq_q <= flash_host_pkg::S_IDLE;
          end
        end
        flash_host_pkg::S_RD1, flash_host_pkg::S_RD3: begin
          if (cycDone_q) begin
            first_q  <= cycRd_q;
            cycReq_q <= 1'b1;
            seq_q    <= (seq_q == flash_host_pkg::S_RD1) ? flash_host_pkg::S_RD2
                                                         : flash_host_pkg::S_RD4;
          end
        end
        flash_host_pkg::S_RD2: begin
          if (cycDone_q) begin
            rdataReg_q <= cycRd_q;
            tog2_q     <= first_q[flash_host_pkg::TOGGLE2_BIT]
                          ^ cycRd_q[flash_host_pkg::TOGGLE2_BIT];
            if (!tog1Diff) begin
              ok_q  <= 1'b1;
              seq_q <= flash_host_pkg::S_IDLE;
            end else if (cycRd_q[flash_host_pkg::FAIL_BIT]) begin
              // The flag may have stopped just as the fail bit rose, so look again.
              cycReq_q <= 1'b1;
              seq_q    <= flash_host_pkg::S_RD3;
            end else begin
              // Still running: hand back to software, which must reissue the poll.
              toggles_q <= 1'b1;
              seq_q     <= flash_host_pkg::S_IDLE;
            end
          end
        end
        flash_host_pkg::S_RD4: begin
          if (cycDone_q) begin
            rdataReg_q <= cycRd_q;
            if (!tog1Diff) begin
              ok_q  <= 1'b1;
              seq_q <= flash_host_pkg::S_IDLE;
            end else begin
              fail_q    <= 1'b1;
              cycReq_q  <= 1'b1;
              cycWr_q   <= 1'b1;
              cycData_q <= RESET_CMD;
              seq_q     <= flash_host_pkg::S_RESET;
            end
          end
        end
        flash_host_pkg::S_RESET: begin
          if (cycDone_q) begin
            ok_q  <= !fail_q;
            seq_q <= flash_host_pkg::S_IDLE;
          end
        end
        flash_host_pkg::S_PRE: begin
          // Checking every time is always safe, whatever the command spacing.
          if (cycDone_q) begin
            winPre_q  <= cycRd_q[flash_host_pkg::WINDOW_BIT];
            cycReq_q  <= 1'b1;
            cycWr_q   <= 1'b1;
            cycData_q <= flash_host_pkg::SECTOR_ERASE_CODE;
            seq_q     <= flash_host_pkg::S_CMD;
          end
        end
        flash_host_pkg::S_CMD: begin
          if (cycDone_q) begin
            cycReq_q <= 1'b1;
            cycWr_q  <= 1'b0;
            seq_q    <= flash_host_pkg::S_POST;
          end
        end
        flash_host_pkg::S_POST: begin
          if (cycDone_q) begin
            winPost_q  <= cycRd_q[flash_host_pkg::WINDOW_BIT];
            reject_q   <= cycRd_q[flash_host_pkg::WINDOW_BIT];
            rdataReg_q <= cycRd_q;
            ok_q       <= 1'b1;
            seq_q      <= flash_host_pkg::S_IDLE;
          end
        end
        default: seq_q <= flash_host_pkg::S_IDLE;
      endcase
    end
  end

  // Helper count of completed reads in the current command, for checking only.
  always_ff @(posedge mclk) begin
    if (!resetn || startCmd_q) begin
      readCount_q <= 3'h0;
    end else if (cycDone_q && !cycWr_q && readCount_q != 3'h7) begin
      readCount_q <= readCount_q + 3'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence readPulse_s;
    !oeN && !ceN && weN && !dqOe;
  endsequence

  read_strobe_a: assert property ((cyc_q == flash_host_pkg::C_READ) |-> readPulse_s)
    else $error("read cycle strobes wrong");
  read_gap_a: assert property ($rose(oeN) |-> oeN [*1] ##1 (oeN && ceN))
    else $error("read strobe not released between reads");
  // The helper count lags the done pulse by one edge, so the second read still shows as one.
  double_read_a: assert property ((seq_q == flash_host_pkg::S_RD2 && cycDone_q)
    |-> readCount_q == 3'h1)
    else $error("poll decided before two reads");
  fail_reset_a: assert property ((seq_q == flash_host_pkg::S_RD4 && cycDone_q && tog1Diff)
    |=> (seq_q == flash_host_pkg::S_RESET && fail_q))
    else $error("failure did not lead to reset");
  poll_restart_a: assert property ((seqIdle && startCmd_q
    && cmd_q == flash_host_pkg::CMD_POLL) |=> (seq_q == flash_host_pkg::S_RD1 && cycReq_q))
    else $error("poll did not restart at first read");
  reset_data_a: assert property ((seq_q == flash_host_pkg::S_RESET && !weN)
    |-> (dqOe && dqOut == RESET_CMD))
    else $error("reset command byte wrong");
  window_check_a: assert property ($rose(seq_q == flash_host_pkg::S_CMD) |->
    $past(seq_q) == flash_host_pkg::S_PRE ##[1:40] (seq_q == flash_host_pkg::S_POST))
    else $error("erase add not bracketed by window reads");
  addr_stable_a: assert property ((!seqIdle && !oeN) |-> $stable(flashAddr))
    else $error("address moved during status read");

endmodule

`default_nettype wire

// ---- core/flash_host_pkg.sv ----
// Constants shared by the flash status-polling host controller.
package flash_host_pkg;

  // Register word offsets on the AHB-Lite side.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] ADDR_OFS   = 8'h04;
  localparam logic [7:0] WDATA_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] RDATA_OFS  = 8'h10;

  // Command codes written into the low bits of the control register.
  localparam logic [2:0] CMD_READ   = 3'h1;
  localparam logic [2:0] CMD_WRITE  = 3'h2;
  localparam logic [2:0] CMD_POLL   = 3'h3;
  localparam logic [2:0] CMD_RESET  = 3'h4;
  localparam logic [2:0] CMD_SECTOR = 3'h5;

  // Bit positions of the status flags on the flash data lines.
  localparam int POLL_BIT    = 7;
  localparam int TOGGLE1_BIT = 6;
  localparam int FAIL_BIT    = 5;
  localparam int WINDOW_BIT  = 3;
  localparam int TOGGLE2_BIT = 2;

  // Status register field positions.
  localparam int ST_BUSY    = 0;
  localparam int ST_OK      = 1;
  localparam int ST_FAIL    = 2;
  localparam int ST_TOGGLES = 3;
  localparam int ST_TOG2    = 4;
  localparam int ST_WINPRE  = 5;
  localparam int ST_WINPOST = 6;
  localparam int ST_REJECT  = 7;
  localparam int ST_READY   = 8;

  // Flash command bytes used by the controller itself.
  localparam logic [7:0] SECTOR_ERASE_CODE = 8'h30;

  // Timing: clock period, read cycle time, write pulse width and recovery gap.
  localparam int CLK_NS      = 40;
  localparam int T_RC_NS     = 70;
  localparam int T_WP_NS     = 35;
  localparam int T_GAP_NS    = 40;
  localparam int SYNC_STAGES = 2;
  localparam int READ_CYCLES = (T_RC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int WP_CYCLES   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYCLES  = (T_GAP_NS + CLK_NS - 1) / CLK_NS;

  // Bus cycle engine states.
  typedef enum logic [3:0] {
    C_IDLE  = 4'b0001,
    C_READ  = 4'b0010,
    C_WRITE = 4'b0100,
    C_GAP   = 4'b1000
  } cyc_t;

  // Command sequencer states.
  typedef enum logic [9:0] {
    S_IDLE   = 10'b0000000001,
    S_SINGLE = 10'b0000000010,
    S_RD1    = 10'b0000000100,
    S_RD2    = 10'b0000001000,
    S_RD3    = 10'b0000010000,
    S_RD4    = 10'b0000100000,
    S_RESET  = 10'b0001000000,
    S_PRE    = 10'b0010000000,
    S_CMD    = 10'b0100000000,
    S_POST   = 10'b1000000000
  } seq_t;

endpackage

// ---- testbench/flash_dev_model.sv ----
// Behavioural flash device that answers reads with status flags while busy.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
  parameter logic [7:0] RESET_CODE  = 8'hf0,
  parameter logic [7:0] SECTOR_CODE = 8'h30
) (
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  hostDq,
  input  wire logic        hostOe,
  input  wire logic        ceN,
  input  wire logic        oeN,
  input  wire logic        weN,
  input  wire logic        loadOp,
  input  wire logic [1:0]  opMode,
  input  wire logic [7:0]  busyReads,
  input  wire logic [7:0]  winReads,
  output logic [7:0]       dqWire,
  output logic             rbLowEn,
  output logic             busy,
  output logic [7:0]       readCount,
  output logic [7:0]       sectorAccepted
);
  logic [7:0] mem [16];
  logic [7:0] devByte;
  logic [7:0] lastVal;
  logic [7:0] winCount;
  logic [1:0] mode;
  logic       tog1;
  logic       tog2;
  logic       failFlag;
  logic       done;
  logic       readOn;

  // Mode 0 idle, 1 ends after busyReads reads, 2 fails for good, 3 fails then stops.
  assign readOn  = !ceN && !oeN;
  assign busy    = (mode != 2'd0) && !done;
  assign rbLowEn = busy;
  assign devByte = busy ? {1'b0, tog1, failFlag, 1'b0, winCount >= winReads, tog2, 2'b00}
                        : mem[addr[3:0]];
  // A released bus shows the inverse of its last value so stale data never passes.
  always @(hostOe, hostDq, readOn, devByte) begin
    if (hostOe === 1'b1) lastVal = hostDq;
    else if (readOn) lastVal = devByte;
  end
  assign dqWire = (hostOe === 1'b1) ? hostDq : (readOn ? devByte : ~lastVal);

  // The bench arms a fresh operation; failure modes show the fail flag at once.
  always @(posedge loadOp) begin
    mode = opMode;
    done = 1'b0;
    tog1 = 1'b0;
    tog2 = 1'b0;
    failFlag = opMode[1];
    winCount = 8'd0;
    readCount = 8'd0;
    sectorAccepted = 8'd0;
  end

  // Each finished read, by either strobe, advances both toggle flags while busy.
  always @(negedge readOn) begin
    readCount = readCount + 8'd1;
    if (busy) begin
      tog1 = !tog1;
      tog2 = !tog2;
      if (winCount != 8'hff) winCount = winCount + 8'd1;
      // A protected or skipped target just toggles for a while, then array read returns.
      if (mode != 2'd2 && readCount >= busyReads) done = 1'b1;
    end
  end

  // Commands and program data latch as the write strobe rises.
  always @(posedge weN) begin
    if (hostOe !== 1'b1) begin
    end else if (hostDq == RESET_CODE) begin
      done = 1'b1;
      failFlag = 1'b0;
    end else if (hostDq == SECTOR_CODE) begin
      if (busy && winCount < winReads) begin
        winCount = 8'd0;
        sectorAccepted = sectorAccepted + 8'd1;
      end
    end else if (!busy) begin
      mem[addr[3:0]] = mem[addr[3:0]] & hostDq;
    end
  end

  // Array contents follow a simple pattern the bench can predict.
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = 8'ha0 ^ 8'(i);
    mode = 2'd0;
    done = 1'b0;
    lastVal = 8'h00;
  end
endmodule
`default_nettype wire

// ---- testbench/flash_host_tb.sv ----
// Self-checking bench for the flash status-polling host controller.
`timescale 1ns/1ps
`default_nettype none
module flash_host_tb;
  typedef struct packed {
    logic [1:0] mode;
    logic [7:0] busyN;
    logic [8:0] expStatus;
    logic [7:0] expReads;
  } row_t;

  logic        mclk, resetn, hsel, hwrite, hready, hreadyout, hresp, dqOe, ceN, oeN, weN;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [2:0]  hsize;
  logic [1:0]  htrans, opMode;
  logic [19:0] flashAddr;
  logic [7:0]  dqIn, dqOut, busyReads, winReads, readCount, sectorAccepted;
  logic        readyBusyIn, rbLowEn, devBusy, loadOp;
  int          errors = 0;
  int          checks_done = 0;
  row_t        rows [4] = '{'{2'd0, 8'd0, 9'h102, 8'd2}, '{2'd1, 8'd100, 9'h018, 8'd2},
                            '{2'd2, 8'd0, 9'h114, 8'd4}, '{2'd3, 8'd2, 9'h112, 8'd4}};
  logic [8:0]  restart [4] = '{9'h018, 9'h018, 9'h118, 9'h102};

  // Single slave, so its ready is the bus ready; ready/busy has a pull-up.
  assign hready      = hreadyout;
  assign readyBusyIn = ~rbLowEn;

  flash_host i_dut (.mclk(mclk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .flashAddr(flashAddr), .dqIn(dqIn), .dqOut(dqOut),
    .dqOe(dqOe), .ceN(ceN), .oeN(oeN), .weN(weN), .readyBusyIn(readyBusyIn));

  flash_dev_model i_flash (.addr(flashAddr), .hostDq(dqOut), .hostOe(dqOe), .ceN(ceN),
    .oeN(oeN), .weN(weN), .loadOp(loadOp), .opMode(opMode), .busyReads(busyReads),
    .winReads(winReads), .dqWire(dqIn), .rbLowEn(rbLowEn), .busy(devBusy),
    .readCount(readCount), .sectorAccepted(sectorAccepted));

  // Free-running 25 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // One whole-word transfer; each phase is held until ready is sampled high.
  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] rdat);
    @(posedge mclk);
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Launch a command, wait for idle, then fetch a settled status word.
  task automatic run_cmd(input logic [2:0] code);
    int n;
    ahb_xfer(1'b1, flash_host_pkg::CTRL_OFS, {29'h0, code}, rd);
    n = 0;
    do begin
      ahb_xfer(1'b0, flash_host_pkg::STATUS_OFS, 32'h0, rd);
      n++;
    end while (rd[flash_host_pkg::ST_BUSY] !== 1'b0 && n < 300);
    check("busy cleared", 32'h0, {31'h0, n >= 300});
    repeat (4) @(posedge mclk);
    ahb_xfer(1'b0, flash_host_pkg::STATUS_OFS, 32'h0, rd);
  endtask

  task automatic load(input logic [1:0] m, input logic [7:0] n, input logic [7:0] w);
    @(posedge mclk);
    opMode    <= m;
    busyReads <= n;
    winReads  <= w;
    loadOp    <= 1'b1;
    @(posedge mclk);
    loadOp    <= 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run of about five hundred cycles.
  initial begin
    #2_000_000;
    errors++;
    $display("watchdog expired");
    final_report();
  end

  // Main sequence: reset values, table of poll outcomes, then awkward cases.
  initial begin
    {hsel, hwrite, loadOp, resetn} = 4'b1000;
    {haddr, hwdata} = 64'h0;
    {htrans, opMode, busyReads, winReads} = 20'h0;
    hsize = 3'h2;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    ahb_xfer(1'b1, 8'h14, 32'hffffffff, rd);
    foreach (rows[i]) begin
      ahb_xfer(1'b0, 8'(i * 4), 32'h0, rd);
      check("reset word", (8'(i * 4) == flash_host_pkg::STATUS_OFS) ? 32'h100 : 32'h0, rd);
    end
    ahb_xfer(1'b0, flash_host_pkg::STATUS_OFS, 32'h0, rd);
    check("reset status", 32'h100, rd);
    check("okay response", 32'h0, {31'h0, hresp});
    ahb_xfer(1'b0, 8'h14, 32'h0, rd);
    check("unmapped", 32'h0, rd);
    ahb_xfer(1'b1, flash_host_pkg::ADDR_OFS, 32'hfff12345, rd);
    ahb_xfer(1'b0, flash_host_pkg::ADDR_OFS, 32'h0, rd);
    check("addr reg", 32'h00012345, rd);
    $display("test registers done");
    foreach (rows[i]) begin
      load(rows[i].mode, rows[i].busyN, 8'd3);
      run_cmd(flash_host_pkg::CMD_POLL);
      check("poll status", {23'h0, rows[i].expStatus}, rd);
      check("read count", {24'h0, rows[i].expReads}, {24'h0, readCount});
      check("device busy", {31'h0, rows[i].mode == 2'd1}, {31'h0, devBusy});
      check("poll addr", 32'h00012345, {12'h0, flashAddr});
      $display("test poll row %0d done", i);
    end
    load(2'd1, 8'd6, 8'd3);
    foreach (restart[i]) begin
      run_cmd(flash_host_pkg::CMD_POLL);
      check("restart status", {23'h0, restart[i]}, rd);
    end
    ahb_xfer(1'b0, flash_host_pkg::RDATA_OFS, 32'h0, rd);
    check("array after done", 32'h000000a5, rd);
    $display("test abandon restart done");
    load(2'd0, 8'd0, 8'd3);
    ahb_xfer(1'b1, flash_host_pkg::CTRL_OFS, {29'h0, flash_host_pkg::CMD_POLL}, rd);
    run_cmd(flash_host_pkg::CMD_READ);
    ahb_xfer(1'b0, flash_host_pkg::CTRL_OFS, 32'h0, rd);
    check("dropped ctrl", {29'h0, flash_host_pkg::CMD_POLL}, rd);
    check("dropped reads", 32'd2, {24'h0, readCount});
    ahb_xfer(1'b1, flash_host_pkg::WDATA_OFS, 32'h0000000f, rd);
    run_cmd(flash_host_pkg::CMD_WRITE);
    run_cmd(flash_host_pkg::CMD_READ);
    ahb_xfer(1'b0, flash_host_pkg::RDATA_OFS, 32'h0, rd);
    check("programmed byte", 32'h00000005, rd);
    $display("test busy drop and program done");
    load(2'd1, 8'd100, 8'd2);
    run_cmd(flash_host_pkg::CMD_SECTOR);
    check("sector open", 32'h02, rd & 32'he2);
    check("sector taken", 32'd1, {24'h0, sectorAccepted});
    run_cmd(flash_host_pkg::CMD_POLL);
    run_cmd(flash_host_pkg::CMD_SECTOR);
    check("sector closed", 32'he2, rd & 32'he2);
    check("sector refused", 32'd1, {24'h0, sectorAccepted});
    run_cmd(flash_host_pkg::CMD_RESET);
    check("reset cmd", 32'h0, {31'h0, devBusy});
    $display("test sector window done");
    // Reset in the middle of a status read must drop the strobes and the busy state.
    load(2'd1, 8'd100, 8'd3);
    ahb_xfer(1'b1, flash_host_pkg::CTRL_OFS, {29'h0, flash_host_pkg::CMD_POLL}, rd);
    repeat (3) @(posedge mclk);
    resetn <= 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    check("strobes after reset", 32'h7, {29'h0, ceN, oeN, weN});
    ahb_xfer(1'b0, flash_host_pkg::STATUS_OFS, 32'h0, rd);
    check("status after reset", 32'h0, rd);
    $display("test mid-run reset done");
    final_report();
  end
endmodule
`default_nettype wire
